// File: hw/pzd_regs.sv
// AXI4-Lite register slice: zero-delay control and PLL status readback.
// Assumes status levels arrive from analog monitors on other clocks.
//
// Notes on behaviour
// - zero-delay enable lives at control bit 1
// - control bit 2 picks external feedback mode
// - status bit 6 shows VCO calibration done
// - status bit 5 shows actual holdover state
// - status bit 4 shows reference two selected
// - status bit 3 shows VCO above threshold
// - status bit 2 shows reference two above threshold
// - status bit 1 shows reference one above threshold
// - status bit 0 shows digital lock detect
// - readback-disable bit freezes status register updates
// - control bits 4:3 pick feedback channel divider
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
module pzd_regs (
  input wire logic ref_clk_in, // 200 MHz clock
  input wire logic rst_in, // Async reset, active high
  // AXI4-Lite slave
  input wire logic [pzd_pkg::ADDR_W-1:0] s_axi_awaddr_in, // Write address
  input wire logic s_axi_awvalid_in, // Write address valid
  output logic s_axi_awready_out, // Write address ready
  input wire logic [31:0] s_axi_wdata_in, // Write data
  input wire logic [3:0] s_axi_wstrb_in, // Write strobes
  input wire logic s_axi_wvalid_in, // Write data valid
  output logic s_axi_wready_out, // Write data ready
  output logic [1:0] s_axi_bresp_out, // Write response
  output logic s_axi_bvalid_out, // Write response valid
  input wire logic s_axi_bready_in, // Write response ready
  input wire logic [pzd_pkg::ADDR_W-1:0] s_axi_araddr_in, // Read address
  input wire logic s_axi_arvalid_in, // Read address valid
  output logic s_axi_arready_out, // Read address ready
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  output logic s_axi_rvalid_out, // Read data valid
  input wire logic s_axi_rready_in, // Read data ready
  // Status sources
  input wire logic cal_done_in, // VCO calibration finished
  input wire logic holdover_active_in, // PLL in holdover state
  input wire logic ref_two_selected_in, // Reference two feeds PLL
  input wire logic vco_above_in, // VCO above threshold
  input wire logic ref_two_above_in, // Reference two above threshold
  input wire logic ref_one_above_in, // Reference one above threshold
  input wire logic lock_detect_in, // Digital lock detect
  // Controls to the PLL
  output logic zero_delay_enable_out, // Zero-delay function on
  output logic zero_delay_external_out, // External feedback in effect
  output logic [1:0] feedback_divider_sel_out, // Feedback channel divider
  output logic threshold_sel_out // Reference monitor threshold select
);

  // ==========================================================================
  // Address decode, one-hot {sts, zdc, stc, thr}
  function automatic logic [3:0] reg_sel(
    input logic [pzd_pkg::ADDR_W-1:0] addr
  );
    reg_sel = {addr == pzd_pkg::STS_ADDR, addr == pzd_pkg::ZDC_ADDR,
               addr == pzd_pkg::STC_ADDR, addr == pzd_pkg::THR_ADDR};
  endfunction

  logic [pzd_pkg::ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] zdc_ff;
  logic [7:0] stc_ff;
  logic [7:0] thr_ff;
  logic [7:0] sts_ff;
  logic ext_mode_ff;
  logic [pzd_pkg::STS_W-1:0] status_sync;

  // ==========================================================================
  // Status synchronisers
  pzd_sync #(
    .W(pzd_pkg::STS_W)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in({cal_done_in, holdover_active_in,
               ref_two_selected_in, vco_above_in,
               ref_two_above_in, ref_one_above_in,
               lock_detect_in}),
    .sync_out(status_sync)
  );

  // ==========================================================================
  // Write channel decode
  wire aw_take = s_axi_awvalid_in & awready_ff;
  wire w_take = s_axi_wvalid_in & wready_ff;
  wire b_done = bvalid_ff & s_axi_bready_in;
  wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire [3:0] wsel = reg_sel(awaddr_ff);
  wire lane0 = wstrb_ff[0];
  wire wr_thr = do_write & wsel[0] & lane0;
  wire wr_stc = do_write & wsel[1] & lane0;
  wire wr_zdc = do_write & wsel[2] & lane0;
  wire wr_mapped = |wsel;
  wire nxt_aw_held = (aw_held_ff | aw_take) & ~do_write;
  wire nxt_w_held = (w_held_ff | w_take) & ~do_write;
  wire nxt_bvalid = (bvalid_ff & ~b_done) | do_write;
  // Hold further writes off until the response has been taken
  wire nxt_awready = ~nxt_aw_held & ~nxt_bvalid;
  wire nxt_wready = ~nxt_w_held & ~nxt_bvalid;

  // Writes to status fall through harmlessly with OKAY
  wire [1:0] nxt_bresp = wr_mapped ? pzd_pkg::RESP_OKAY :
                         pzd_pkg::RESP_SLVERR;

  // ==========================================================================
  // Write address and data capture, in either order
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr_in;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata_in;
        wstrb_ff <= s_axi_wstrb_in;
      end
    end
  end

  // Write handshake state
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= pzd_pkg::RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      if (do_write) begin
        bresp_ff <= nxt_bresp;
      end
    end
  end

  // ==========================================================================
  // Control registers; unused bits are masked away
  wire [7:0] wbyte = wdata_ff[7:0];
  wire [7:0] nxt_zdc = wr_zdc ? (wbyte & pzd_pkg::ZDC_MASK) : zdc_ff;
  wire [7:0] nxt_stc = wr_stc ? (wbyte & pzd_pkg::STC_MASK) : stc_ff;
  wire [7:0] nxt_thr = wr_thr ? (wbyte & pzd_pkg::THR_MASK) : thr_ff;
  // External mode counts only while zero delay is enabled
  wire nxt_ext_mode = nxt_zdc[pzd_pkg::ZDC_EN_BIT] &
                      nxt_zdc[pzd_pkg::ZDC_EXT_BIT];

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      zdc_ff <= pzd_pkg::REG_RESET;
      stc_ff <= pzd_pkg::REG_RESET;
      thr_ff <= pzd_pkg::REG_RESET;
      ext_mode_ff <= 1'b0;
    end else begin
      zdc_ff <= nxt_zdc;
      stc_ff <= nxt_stc;
      thr_ff <= nxt_thr;
      ext_mode_ff <= nxt_ext_mode;
    end
  end

  // ==========================================================================
  // Status capture; freezing gives software a coherent snapshot
  wire freeze = stc_ff[pzd_pkg::STC_FREEZE_BIT];
  wire [7:0] nxt_sts = freeze ? sts_ff : {1'b0, status_sync};

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sts_ff <= pzd_pkg::REG_RESET;
    end else begin
      sts_ff <= nxt_sts;
    end
  end

  // ==========================================================================
  // Read channel
  wire ar_take = s_axi_arvalid_in & arready_ff;
  wire r_done = rvalid_ff & s_axi_rready_in;
  wire [3:0] rsel = reg_sel(s_axi_araddr_in);
  wire [7:0] rbyte = ({8{rsel[0]}} & thr_ff) | ({8{rsel[1]}} & stc_ff) |
                     ({8{rsel[2]}} & zdc_ff) | ({8{rsel[3]}} & sts_ff);
  wire [1:0] nxt_rresp = (|rsel) ? pzd_pkg::RESP_OKAY :
                         pzd_pkg::RESP_SLVERR;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= pzd_pkg::RESP_OKAY;
    end else begin
      arready_ff <= ~((rvalid_ff & ~r_done) | ar_take);
      rvalid_ff <= (rvalid_ff & ~r_done) | ar_take;
      if (ar_take) begin
        rdata_ff <= {24'h00_0000, rbyte};
        rresp_ff <= nxt_rresp;
      end
    end
  end

  // ==========================================================================
  // Output drive
  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign zero_delay_enable_out = zdc_ff[pzd_pkg::ZDC_EN_BIT];
  assign zero_delay_external_out = ext_mode_ff;
  assign feedback_divider_sel_out =
    zdc_ff[pzd_pkg::ZDC_DIV_HI:pzd_pkg::ZDC_DIV_LO];
  assign threshold_sel_out = thr_ff[pzd_pkg::THR_SEL_BIT];

  // ==========================================================================
  // Checks
  AST_ZD_ENABLE: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    wr_zdc |=> zero_delay_enable_out == $past(wbyte[pzd_pkg::ZDC_EN_BIT]))
    else $error("zero-delay enable did not follow write");

  AST_ZD_EXT: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    wr_zdc |=> zero_delay_external_out ==
      $past(wbyte[pzd_pkg::ZDC_EN_BIT] & wbyte[pzd_pkg::ZDC_EXT_BIT]))
    else $error("external mode not gated by enable");

  AST_DIV_SEL: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    wr_zdc |=> feedback_divider_sel_out ==
      $past(wbyte[pzd_pkg::ZDC_DIV_HI:pzd_pkg::ZDC_DIV_LO]))
    else $error("divider select did not follow write");

  AST_STS_CAL: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    !freeze |=> sts_ff[pzd_pkg::STS_CAL_BIT] ==
      $past(status_sync[pzd_pkg::STS_CAL_BIT]))
    else $error("calibration status not tracked");

  AST_STS_HOLD: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    !freeze |=> sts_ff[pzd_pkg::STS_HOLD_BIT] ==
      $past(status_sync[pzd_pkg::STS_HOLD_BIT]))
    else $error("holdover status not tracked");

  AST_STS_REFSEL: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    !freeze |=> sts_ff[pzd_pkg::STS_REFSEL_BIT] ==
      $past(status_sync[pzd_pkg::STS_REFSEL_BIT]))
    else $error("reference select status not tracked");

  AST_STS_VCO: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    !freeze |=> sts_ff[pzd_pkg::STS_VCO_BIT] ==
      $past(status_sync[pzd_pkg::STS_VCO_BIT]))
    else $error("VCO threshold status not tracked");

  AST_STS_REFERENCE_INPUT_TWO: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    !freeze |=> sts_ff[pzd_pkg::STS_REFERENCE_INPUT_TWO_BIT] ==
      $past(status_sync[pzd_pkg::STS_REFERENCE_INPUT_TWO_BIT]))
    else $error("reference two threshold not tracked");

  AST_STS_REFERENCE_INPUT_ONE: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    !freeze |=> sts_ff[pzd_pkg::STS_REFERENCE_INPUT_ONE_BIT] ==
      $past(status_sync[pzd_pkg::STS_REFERENCE_INPUT_ONE_BIT]))
    else $error("reference one threshold not tracked");

  AST_STS_LOCK: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    !freeze |=> sts_ff[pzd_pkg::STS_LOCK_BIT] ==
      $past(status_sync[pzd_pkg::STS_LOCK_BIT]))
    else $error("lock detect not tracked");

  AST_FREEZE: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    freeze |=> $stable(sts_ff))
    else $error("status changed while frozen");

  AST_UNUSED_ZERO: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    rvalid_ff |-> rdata_ff[31:8] == 24'h00_0000 &&
      !sts_ff[pzd_pkg::STS_TOP_BIT] && !zdc_ff[0])
    else $error("unused bits read nonzero");

  AST_B_TIMING: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    aw_held_ff && w_held_ff && !bvalid_ff |=> bvalid_ff)
    else $error("write response late");

endmodule // pzd_regs

// File: include/pzd_pkg.sv
// Package for the PLL zero-delay and status register slice.
// Assumes a 32-bit AXI4-Lite bus; each register takes one aligned word.
package pzd_pkg;

  // ==========================================================================
  // Register indices and byte addresses (byte address is four times index)
  localparam int ADDR_W = 12;
  localparam logic [7:0] THR_IDX = 8'h1a;
  localparam logic [7:0] STC_IDX = 8'h1d;
  localparam logic [7:0] ZDC_IDX = 8'h1e;
  localparam logic [7:0] STS_IDX = 8'h1f;
  localparam logic [ADDR_W-1:0] THR_ADDR = {2'h0, THR_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STC_ADDR = {2'h0, STC_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] ZDC_ADDR = {2'h0, ZDC_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STS_ADDR = {2'h0, STS_IDX, 2'h0};

  // ==========================================================================
  // Field positions
  localparam int ZDC_EN_BIT = 1;
  localparam int ZDC_EXT_BIT = 2;
  localparam int ZDC_DIV_LO = 3;
  localparam int ZDC_DIV_HI = 4;
  localparam int STC_FREEZE_BIT = 4;
  localparam int THR_SEL_BIT = 6;
  localparam int STS_LOCK_BIT = 0;
  localparam int STS_REFERENCE_INPUT_ONE_BIT = 1;
  localparam int STS_REFERENCE_INPUT_TWO_BIT = 2;
  localparam int STS_VCO_BIT = 3;
  localparam int STS_REFSEL_BIT = 4;
  localparam int STS_HOLD_BIT = 5;
  localparam int STS_CAL_BIT = 6;
  localparam int STS_TOP_BIT = 7;
  localparam int STS_W = 7;

  // ==========================================================================
  // Writable masks and reset values
  localparam logic [7:0] ZDC_MASK = 8'h1e;
  localparam logic [7:0] STC_MASK = 8'h10;
  localparam logic [7:0] THR_MASK = 8'h40;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hw/pzd_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/100ps
module pzd_sync #(
  parameter int W = 7
) (
  input wire logic ref_clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic [W-1:0] async_in, // Levels from outside the domain
  output logic [W-1:0] sync_out // Synchronised levels
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // ==========================================================================
  // Stage one is read only by stage two
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // pzd_sync

// File: test/test_pll_zero_delay_status_regs.sv
// Self-checking bench for the zero-delay control and PLL status slice.
// Assumes pzd_regs as the top; the bench acts as AXI4-Lite master.
`timescale 1ns/100ps
module test_pll_zero_delay_status_regs;
  // ==========================================================================
  // Signals
  logic clk;
  logic rst;
  logic [pzd_pkg::ADDR_W-1:0] awaddr;
  logic [pzd_pkg::ADDR_W-1:0] araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [6:0] src;
  logic zd_en, zd_ext, thr_sel;
  logic [1:0] div_sel;
  int fail_count;
  int n_checks;
  int cycles;

  pzd_regs uut (
    .ref_clk_in(clk), .rst_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready),
    .cal_done_in(src[6]), .holdover_active_in(src[5]),
    .ref_two_selected_in(src[4]), .vco_above_in(src[3]),
    .ref_two_above_in(src[2]), .ref_one_above_in(src[1]),
    .lock_detect_in(src[0]),
    .zero_delay_enable_out(zd_en), .zero_delay_external_out(zd_ext),
    .feedback_divider_sel_out(div_sel), .threshold_sel_out(thr_sel)
  );

  // ==========================================================================
  // Clock and hang guard; a wedged handshake would otherwise spin forever
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Write: offer both channels, drop each when taken, then wait response
  task automatic wr(input logic [pzd_pkg::ADDR_W-1:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    chk("bresp", 32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask

  // Read: data and response are taken at the rvalid edge
  task automatic rd(input logic [pzd_pkg::ADDR_W-1:0] a,
                    input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    chk("rdata", rdata, ed);
    chk("rresp", 32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    int i;
    logic [7:0] v;
    rst = 1'b1;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    src = 7'h00;
    fail_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Reset defaults: function off, internal mode, divider 0
    rd(pzd_pkg::ZDC_ADDR, 32'h0, 2'h0);
    chk("ctl_outs", 32'({zd_en, zd_ext, div_sel, thr_sel}), 32'h0);
    rd(pzd_pkg::STS_ADDR, 32'h0, 2'h0);
    // Every combination of bits 4:1, unused bits written as ones
    for (i = 0; i < 16; i++) begin
      v = 8'(i << 1) | 8'he1;
      wr(pzd_pkg::ZDC_ADDR, {24'hffffff, v}, 4'hf, 2'h0);
      rd(pzd_pkg::ZDC_ADDR, {24'h0, v & 8'h1e}, 2'h0);
      chk("zd_en", 32'(zd_en), 32'(v[1]));
      chk("zd_ext", 32'(zd_ext), 32'(v[1] & v[2]));
      chk("div_sel", 32'(div_sel), 32'(v[4:3]));
    end
    // Byte lane 0 off: the write is answered but must not land
    wr(pzd_pkg::ZDC_ADDR, 32'h0, 4'he, 2'h0);
    rd(pzd_pkg::ZDC_ADDR, 32'h1e, 2'h0);
    // Threshold select feeding both reference monitors
    wr(pzd_pkg::THR_ADDR, 32'hff, 4'h1, 2'h0);
    rd(pzd_pkg::THR_ADDR, 32'h40, 2'h0);
    chk("thr_sel", 32'(thr_sel), 32'h1);
    wr(pzd_pkg::THR_ADDR, 32'h0, 4'h1, 2'h0);
    chk("thr_sel", 32'(thr_sel), 32'h0);
    // Walk one status source at a time; sync plus capture takes 3 edges
    for (i = 0; i < 7; i++) begin
      src <= 7'(1 << i);
      repeat (4) @(posedge clk);
      rd(pzd_pkg::STS_ADDR, 32'(1 << i), 2'h0);
    end
    src <= 7'h7f;
    repeat (4) @(posedge clk);
    // Status is read-only: a write is answered and ignored
    wr(pzd_pkg::STS_ADDR, 32'h0, 4'hf, 2'h0);
    rd(pzd_pkg::STS_ADDR, 32'h7f, 2'h0);
    // Freeze holds the last captured value until released
    wr(pzd_pkg::STC_ADDR, 32'hff, 4'hf, 2'h0);
    rd(pzd_pkg::STC_ADDR, 32'h10, 2'h0);
    src <= 7'h2a;
    repeat (6) @(posedge clk);
    rd(pzd_pkg::STS_ADDR, 32'h7f, 2'h0);
    wr(pzd_pkg::STC_ADDR, 32'h0, 4'hf, 2'h0);
    repeat (4) @(posedge clk);
    rd(pzd_pkg::STS_ADDR, 32'h2a, 2'h0);
    // Unmapped addresses answer with an error and zero data
    wr(12'h000, 32'hff, 4'hf, 2'h2);
    rd(12'h000, 32'h0, 2'h2);
    rd(12'hffc, 32'h0, 2'h2);
    rd(pzd_pkg::ZDC_ADDR, 32'h1e, 2'h0);
    end_of_test();
  end
endmodule // test_pll_zero_delay_status_regs
